// ==== dv/rf_front_end_model.sv ====
`timescale 1ns/1ps
module rf_front_end_model (
	input  wire logic ref_clk,
	input  wire logic rst,
	output logic      miller_envelope,
	output logic      tx_serial_bits,
	output logic      rx_decoded_bits,
	output logic      aux_input_pin,
	output logic      analog_rx_signal,
	output logic      bit_tick,
	output logic [7:0] test_bus
);
	// ****************************************************************
	// Pattern source
	// ****************************************************************
	// Every line has its own pattern (aux_input_pin is miller_envelope inverted) so a wrong pick shows up
	logic [7:0] ph_q;
	always_ff @(posedge ref_clk) begin
		ph_q <= rst ? 8'h00 : ph_q + 8'h01;
	end
	assign miller_envelope  = ph_q[0];
	assign tx_serial_bits   = ph_q[1];
	assign rx_decoded_bits  = ph_q[2];
	assign aux_input_pin    = ~ph_q[0];
	assign analog_rx_signal = ph_q[0] ^ ph_q[1];
	assign test_bus         = ph_q ^ 8'h5A;
	// One bit-clock every four cycles
	assign bit_tick         = (ph_q[1:0] == 2'h3);
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [7:0] tx;
		logic [7:0] rx;
		logic [3:0] aux;
		logic [3:0] ant;
		logic [3:0] dec;
	} row_s;
	// ****************************************************************
	// Rows: pick 0 low, 1 high, 2 miller, 3 tx, 4 rx, 5 test, 6 aux in, 7 analog, 8 off
	// ****************************************************************
	localparam row_s ROWS [9] = '{
		'{8'h00, 8'h04, 4'h8, 4'h8, 4'h0}, '{8'h11, 8'h44, 4'h0, 4'h2, 4'h6},
		'{8'h22, 8'h84, 4'h1, 4'h6, 4'h7}, '{8'h33, 8'hC4, 4'h5, 4'h1, 4'h6},
		'{8'h14, 8'h84, 4'h2, 4'h2, 4'h7}, '{8'h15, 8'h84, 4'h3, 4'h2, 4'h7},
		'{8'h16, 8'h84, 4'h8, 4'h2, 4'h7}, '{8'h17, 8'h84, 4'h4, 4'h2, 4'h7},
		'{8'h1F, 8'h84, 4'h8, 4'h2, 4'h7}};
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er;
	logic soft_power_down = 1'b0, tx_done = 1'b0, cmd_receives = 1'b0;
	logic rx_only_start = 1'b0, rx_stop = 1'b0, rf_field_on = 1'b0, half_bits_valid = 1'b0;
	logic [3:0] rx_strength = 4'h0;
	logic [2:0] weak_half_level = 3'h0;
	logic miller_envelope, tx_serial_bits, rx_decoded_bits, aux_input_pin, analog_rx_signal;
	logic bit_tick;
	logic [7:0] test_bus, pv_q;
	logic antenna_drive_pin_a, antenna_drive_pin_a_oe, antenna_drive_pin_b;
	logic antenna_drive_pin_b_oe, aux_output_pin, aux_output_pin_oe;
	logic decoder_in, rx_enable, signal_accept, bit_collision;
	int num_errors = 0;
	int total_checks = 0;
	int n;

	always #4 ref_clk = ~ref_clk;
	// Inputs seen at the last edge, which registered outputs show now
	always @(posedge ref_clk) begin
		pv_q <= {analog_rx_signal, aux_input_pin, test_bus[3], rx_decoded_bits,
			tx_serial_bits, miller_envelope, 1'b1, 1'b0};
	end

	rf_front_end_model rf_front_end_model_i (.ref_clk(ref_clk), .rst(rst),
		.miller_envelope(miller_envelope), .tx_serial_bits(tx_serial_bits),
		.rx_decoded_bits(rx_decoded_bits), .aux_input_pin(aux_input_pin),
		.analog_rx_signal(analog_rx_signal), .bit_tick(bit_tick), .test_bus(test_bus));
	rf_signal_route_select rf_signal_route_select_i (.ref_clk(ref_clk), .rst(rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.soft_power_down(soft_power_down), .miller_envelope(miller_envelope),
		.tx_serial_bits(tx_serial_bits), .rx_decoded_bits(rx_decoded_bits),
		.test_bus(test_bus), .aux_input_pin(aux_input_pin),
		.analog_rx_signal(analog_rx_signal), .tx_done(tx_done), .cmd_receives(cmd_receives),
		.rx_only_start(rx_only_start), .rx_stop(rx_stop), .rf_field_on(rf_field_on),
		.bit_tick(bit_tick), .rx_strength(rx_strength), .weak_half_level(weak_half_level),
		.half_bits_valid(half_bits_valid), .antenna_drive_pin_a(antenna_drive_pin_a),
		.antenna_drive_pin_a_oe(antenna_drive_pin_a_oe),
		.antenna_drive_pin_b(antenna_drive_pin_b),
		.antenna_drive_pin_b_oe(antenna_drive_pin_b_oe), .aux_output_pin(aux_output_pin),
		.aux_output_pin_oe(aux_output_pin_oe), .decoder_in(decoder_in),
		.rx_enable(rx_enable), .signal_accept(signal_accept), .bit_collision(bit_collision));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Holds the request until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse_stop();
		@(posedge ref_clk);
		rx_stop <= 1'b1;
		@(posedge ref_clk);
		rx_stop <= 1'b0;
	endtask

	task automatic complete_run();
		if (num_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		complete_run();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (16) @(posedge ref_clk);
		check("oe_in_reset", antenna_drive_pin_a_oe, 1'b0);
		rst <= 1'b0;
		apb(1'b0, rf_route_pkg::ADDR_TX_SOURCE, 32'h0);
		check("tx_src_rst", rd, 32'h10);
		apb(1'b0, rf_route_pkg::ADDR_RX_SOURCE, 32'h0);
		check("rx_src_rst", rd, 32'h84);
		apb(1'b1, rf_route_pkg::ADDR_THRESHOLD, 32'hFF);
		apb(1'b0, rf_route_pkg::ADDR_THRESHOLD, 32'h0);
		check("thr_reserved", rd, 32'hF7);
		apb(1'b1, 8'h00, 32'hFF);
		check("unmapped_err", er, 1'b1);
		apb(1'b1, rf_route_pkg::ADDR_THRESHOLD, 32'h84);
		apb(1'b1, rf_route_pkg::ADDR_TEST_SELECT, 32'h3);
		// Power-down must not release pins unless the code says so
		soft_power_down <= 1'b1;
		rx_only_start <= 1'b1;
		@(posedge ref_clk);
		rx_only_start <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, rf_route_pkg::ADDR_TX_SOURCE, {24'h0, ROWS[i].tx});
			apb(1'b1, rf_route_pkg::ADDR_RX_SOURCE, {24'h0, ROWS[i].rx});
			repeat (2) @(posedge ref_clk);
			for (int k = 0; k < 4; k++) begin
				@(negedge ref_clk);
				check("aux_oe", aux_output_pin_oe, ROWS[i].aux != 4'h8);
				if (ROWS[i].aux != 4'h8) check("aux_pin", aux_output_pin, pv_q[ROWS[i].aux]);
				check("ant_a_oe", antenna_drive_pin_a_oe, ROWS[i].ant != 4'h8);
				check("ant_b_oe", antenna_drive_pin_b_oe, ROWS[i].ant != 4'h8);
				if (ROWS[i].ant != 4'h8) check("ant_a", antenna_drive_pin_a, pv_q[ROWS[i].ant]);
				if (ROWS[i].ant != 4'h8) check("ant_b", antenna_drive_pin_b, pv_q[ROWS[i].ant]);
				check("decoder_in", decoder_in, pv_q[ROWS[i].dec]);
			end
		end
		apb(1'b1, rf_route_pkg::ADDR_TX_SOURCE, 32'h30);
		apb(1'b1, rf_route_pkg::ADDR_DRIVE_CTRL, 32'h43);
		repeat (2) @(posedge ref_clk);
		check("high_en", {antenna_drive_pin_a, antenna_drive_pin_b}, 2'b01);
		apb(1'b1, rf_route_pkg::ADDR_DRIVE_CTRL, 32'h20);
		repeat (2) @(posedge ref_clk);
		check("high_dis", {antenna_drive_pin_a, antenna_drive_pin_b}, 2'b10);
		// Guard of three bit-clocks after a receiving transmit
		apb(1'b1, rf_route_pkg::ADDR_RX_SOURCE, 32'h83);
		pulse_stop();
		cmd_receives <= 1'b1;
		tx_done <= 1'b1;
		@(posedge ref_clk);
		tx_done <= 1'b0;
		n = 0;
		while (rx_enable !== 1'b1 && n < 40) begin
			@(negedge ref_clk);
			if (rx_enable !== 1'b1) check("dec_guard", decoder_in, 1'b0);
			n++;
		end
		check("guard_len", n >= 9 && n <= 16, 1'b1);
		pulse_stop();
		rx_only_start <= 1'b1;
		tx_done <= 1'b1;
		@(posedge ref_clk);
		rx_only_start <= 1'b0;
		tx_done <= 1'b0;
		repeat (2) @(negedge ref_clk);
		check("rx_only", rx_enable, 1'b1);
		pulse_stop();
		rf_field_on <= 1'b1;
		apb(1'b0, rf_route_pkg::ADDR_STATUS, 32'h0);
		check("field_guard", rd[7:6], 2'b01);
		for (int j = 0; j < 3; j++) begin
			@(posedge ref_clk);
			rx_strength <= (j == 2) ? 4'h7 : 4'h8;
			weak_half_level <= (j == 0) ? 3'h3 : (j == 1) ? 3'h4 : 3'h7;
			repeat (3) @(posedge ref_clk);
			half_bits_valid <= 1'b1;
			@(posedge ref_clk);
			half_bits_valid <= 1'b0;
			check("accept", signal_accept, j != 2);
			n = 0;
			repeat (3) @(negedge ref_clk) n += (bit_collision === 1'b1);
			check("collision", n, j == 1);
		end
		// Mid-run reset restores the codes and releases the drivers
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check("oe_mid_rst", {antenna_drive_pin_a_oe, antenna_drive_pin_b_oe}, 2'b00);
		rst <= 1'b0;
		apb(1'b0, rf_route_pkg::ADDR_TX_SOURCE, 32'h0);
		check("tx_src_mid", rd, 32'h10);
		complete_run();
	end
endmodule

// ==== verilog/antenna_driver_mux.sv ====
`timescale 1ns/1ps
module antenna_driver_mux (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [1:0] source_code,
	input  wire logic       driver_enabled,
	input  wire logic       invert_enabled,
	input  wire logic       invert_disabled,
	input  wire logic       miller_envelope,
	input  wire logic       aux_input_pin,
	output logic            pin_out,
	output logic            pin_oe
);
	typedef struct packed {
		logic out;
		logic oe;
	} pin_s;

	pin_s state_q;
	pin_s state_d;
	logic inv;

	// Soft power-down never forces the pin; only reset and the tristate code do
	always_comb begin
		inv     = driver_enabled ? invert_enabled : invert_disabled;
		state_d = '{out: 1'b0, oe: 1'b1};
		case (source_code)
			rf_route_pkg::DRV_TRISTATE: state_d.oe  = 1'b0;
			rf_route_pkg::DRV_MILLER:   state_d.out = miller_envelope ^ inv;
			rf_route_pkg::DRV_AUX_IN:   state_d.out = aux_input_pin ^ inv;
			rf_route_pkg::DRV_HIGH:     state_d.out = 1'b1 ^ inv;
			default:                    state_d.oe  = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) state_q <= '{out: 1'b0, oe: 1'b0};
		else     state_q <= state_d;
	end

	assign pin_out = state_q.out;
	assign pin_oe  = state_q.oe;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	drive_tristate_a: assert property (
		source_code == rf_route_pkg::DRV_TRISTATE |=> !pin_oe)
		else $error("antenna pin driven with tristate code");
	static_high_a: assert property (
		source_code == rf_route_pkg::DRV_HIGH && driver_enabled
		|=> pin_oe && pin_out == !$past(invert_enabled))
		else $error("static high level ignores inversion setting");
endmodule

// ==== verilog/guard_delay_counter.sv ====
`timescale 1ns/1ps
module guard_delay_counter (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       load,
	input  wire logic [5:0] delay,
	input  wire logic       bit_tick,
	output logic            busy,
	output logic [5:0]      count
);
	typedef struct packed {
		logic [5:0] count;
	} guard_s;

	guard_s state_q;
	guard_s state_d;

	always_comb begin
		state_d = state_q;
		if (load)
			state_d.count = delay;
		else if (bit_tick && state_q.count != 6'h0)
			state_d.count = state_q.count - 6'h1;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) state_q <= '{count: 6'h0};
		else     state_q <= state_d;
	end

	assign count = state_q.count;
	assign busy  = state_q.count != 6'h0;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	count_hold_a: assert property (
		!load && !bit_tick |=> count == $past(count))
		else $error("guard count moved without a bit tick");
endmodule

// ==== verilog/rf_route_pkg.sv ====
package rf_route_pkg;

	// ****************************************************************
	// Register indices and byte addresses
	// ****************************************************************
	localparam logic [7:0] IDX_DRIVE_CTRL   = 8'h14;
	localparam logic [7:0] IDX_TX_SOURCE    = 8'h16;
	localparam logic [7:0] IDX_RX_SOURCE    = 8'h17;
	localparam logic [7:0] IDX_THRESHOLD    = 8'h18;
	localparam logic [7:0] IDX_STATUS       = 8'h21;
	localparam logic [7:0] IDX_TEST_SELECT  = 8'h31;

	localparam logic [7:0] ADDR_DRIVE_CTRL  = 8'(IDX_DRIVE_CTRL * 4);
	localparam logic [7:0] ADDR_TX_SOURCE   = 8'(IDX_TX_SOURCE * 4);
	localparam logic [7:0] ADDR_RX_SOURCE   = 8'(IDX_RX_SOURCE * 4);
	localparam logic [7:0] ADDR_THRESHOLD   = 8'(IDX_THRESHOLD * 4);
	localparam logic [7:0] ADDR_STATUS      = 8'(IDX_STATUS * 4);
	localparam logic [7:0] ADDR_TEST_SELECT = 8'(IDX_TEST_SELECT * 4);

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] RST_DRIVE_CTRL   = 8'h80;
	localparam logic [7:0] RST_TX_SOURCE    = 8'h10;
	localparam logic [7:0] RST_RX_SOURCE    = 8'h84;
	localparam logic [7:0] RST_THRESHOLD    = 8'h84;
	localparam logic [2:0] RST_TEST_SELECT  = 3'h0;

	// ****************************************************************
	// Writable bit masks, reserved bits stay zero
	// ****************************************************************
	localparam logic [7:0] MASK_DRIVE_CTRL  = 8'hF3;
	localparam logic [7:0] MASK_TX_SOURCE   = 8'h3F;
	localparam logic [7:0] MASK_RX_SOURCE   = 8'hFF;
	localparam logic [7:0] MASK_THRESHOLD   = 8'hF7;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int DRV_SRC_LSB   = 4;
	localparam int AUX_SRC_LSB   = 0;
	localparam int DEC_SEL_LSB   = 6;
	localparam int GUARD_LSB     = 0;
	localparam int MIN_LVL_LSB   = 4;
	localparam int COLL_LSB      = 0;
	localparam int INV_B_ON_BIT  = 7;
	localparam int INV_A_ON_BIT  = 6;
	localparam int INV_B_OFF_BIT = 5;
	localparam int INV_A_OFF_BIT = 4;
	localparam int EN_B_BIT      = 1;
	localparam int EN_A_BIT      = 0;

	// ****************************************************************
	// Codes
	// ****************************************************************
	localparam logic [1:0] DRV_TRISTATE = 2'h0;
	localparam logic [1:0] DRV_MILLER   = 2'h1;
	localparam logic [1:0] DRV_AUX_IN   = 2'h2;
	localparam logic [1:0] DRV_HIGH     = 2'h3;

	localparam logic [3:0] AUX_TRISTATE = 4'h0;
	localparam logic [3:0] AUX_LOW      = 4'h1;
	localparam logic [3:0] AUX_HIGH     = 4'h2;
	localparam logic [3:0] AUX_TEST_BUS = 4'h3;
	localparam logic [3:0] AUX_MILLER   = 4'h4;
	localparam logic [3:0] AUX_TX_BITS  = 4'h5;
	localparam logic [3:0] AUX_RX_BITS  = 4'h7;

	localparam logic [1:0] DEC_LOW      = 2'h0;
	localparam logic [1:0] DEC_AUX_MAN  = 2'h1;
	localparam logic [1:0] DEC_ANALOG   = 2'h2;
	localparam logic [1:0] DEC_AUX_NRZ  = 2'h3;

	typedef enum logic [1:0] {RX_IDLE, RX_GUARD, RX_ACTIVE} rx_state_e;

endpackage

// ==== verilog/rf_signal_route_select.sv ====
`timescale 1ns/1ps
module rf_signal_route_select (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        soft_power_down,
	input  wire logic        miller_envelope,
	input  wire logic        tx_serial_bits,
	input  wire logic        rx_decoded_bits,
	input  wire logic [7:0]  test_bus,
	input  wire logic        aux_input_pin,
	input  wire logic        analog_rx_signal,
	input  wire logic        tx_done,
	input  wire logic        cmd_receives,
	input  wire logic        rx_only_start,
	input  wire logic        rx_stop,
	input  wire logic        rf_field_on,
	input  wire logic        bit_tick,
	input  wire logic [3:0]  rx_strength,
	input  wire logic [2:0]  weak_half_level,
	input  wire logic        half_bits_valid,
	output logic             antenna_drive_pin_a,
	output logic             antenna_drive_pin_a_oe,
	output logic             antenna_drive_pin_b,
	output logic             antenna_drive_pin_b_oe,
	output logic             aux_output_pin,
	output logic             aux_output_pin_oe,
	output logic             decoder_in,
	output logic             rx_enable,
	output logic             signal_accept,
	output logic             bit_collision
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0]              tx_source;
		logic [7:0]              rx_source;
		logic [7:0]              threshold;
		logic [7:0]              drive_ctrl;
		logic [2:0]              test_pick;
		rf_route_pkg::rx_state_e rx_state;
		logic                    field_prev;
		logic                    rx_en;
		logic [31:0]             prdata;
		logic                    pready;
		logic                    pslverr;
		logic                    dec_in;
		logic                    accept;
		logic                    coll;
		logic                    aux_out;
		logic                    aux_oe;
	} state_s;

	state_s state_q;
	state_s state_d;

	logic [1:0] antenna_driver_source;
	logic [3:0] aux_output_source;
	logic [1:0] decoder_input_select;
	logic [5:0] rx_guard_delay;
	logic [3:0] decoder_min_level;
	logic [2:0] collision_threshold;
	logic       guard_busy;
	logic [5:0] guard_count;
	logic       guard_load;
	logic       arm_after_tx;
	logic       field_rise;
	logic       setup_phase;
	logic       write_now;
	logic       addr_hit;
	logic [7:0] read_byte;

	assign antenna_driver_source = state_q.tx_source[rf_route_pkg::DRV_SRC_LSB +: 2];
	assign aux_output_source     = state_q.tx_source[rf_route_pkg::AUX_SRC_LSB +: 4];
	assign decoder_input_select  = state_q.rx_source[rf_route_pkg::DEC_SEL_LSB +: 2];
	assign rx_guard_delay        = state_q.rx_source[rf_route_pkg::GUARD_LSB +: 6];
	assign decoder_min_level     = state_q.threshold[rf_route_pkg::MIN_LVL_LSB +: 4];
	assign collision_threshold   = state_q.threshold[rf_route_pkg::COLL_LSB +: 3];

	// ****************************************************************
	// Receiver guard events
	// ****************************************************************
	// Receive-only never arms the guard, even if tx_done coincides
	assign arm_after_tx = tx_done && cmd_receives && !rx_only_start;
	assign field_rise   = rf_field_on && !state_q.field_prev;
	assign guard_load   = arm_after_tx || field_rise;

	guard_delay_counter u_guard (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.load     (guard_load),
		.delay    (rx_guard_delay),
		.bit_tick (bit_tick),
		.busy     (guard_busy),
		.count    (guard_count)
	);

	// ****************************************************************
	// Antenna drivers
	// ****************************************************************
	// Power-down is a no-op here: only reset and the tristate code release the pins
	antenna_driver_mux u_drive_a (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.source_code     (antenna_driver_source),
		.driver_enabled  (state_q.drive_ctrl[rf_route_pkg::EN_A_BIT]),
		.invert_enabled  (state_q.drive_ctrl[rf_route_pkg::INV_A_ON_BIT]),
		.invert_disabled (state_q.drive_ctrl[rf_route_pkg::INV_A_OFF_BIT]),
		.miller_envelope (miller_envelope),
		.aux_input_pin   (aux_input_pin),
		.pin_out         (antenna_drive_pin_a),
		.pin_oe          (antenna_drive_pin_a_oe)
	);

	antenna_driver_mux u_drive_b (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.source_code     (antenna_driver_source),
		.driver_enabled  (state_q.drive_ctrl[rf_route_pkg::EN_B_BIT]),
		.invert_enabled  (state_q.drive_ctrl[rf_route_pkg::INV_B_ON_BIT]),
		.invert_disabled (state_q.drive_ctrl[rf_route_pkg::INV_B_OFF_BIT]),
		.miller_envelope (miller_envelope),
		.aux_input_pin   (aux_input_pin),
		.pin_out         (antenna_drive_pin_b),
		.pin_oe          (antenna_drive_pin_b_oe)
	);

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	assign setup_phase = psel && !penable;
	assign write_now   = psel && penable && pwrite && state_q.pready && !state_q.pslverr;

	always_comb begin
		addr_hit  = 1'b1;
		read_byte = 8'h00;
		case (paddr)
			rf_route_pkg::ADDR_DRIVE_CTRL:  read_byte = state_q.drive_ctrl;
			rf_route_pkg::ADDR_TX_SOURCE:   read_byte = state_q.tx_source;
			rf_route_pkg::ADDR_RX_SOURCE:   read_byte = state_q.rx_source;
			rf_route_pkg::ADDR_THRESHOLD:   read_byte = state_q.threshold;
			rf_route_pkg::ADDR_TEST_SELECT: read_byte = {5'h00, state_q.test_pick};
			rf_route_pkg::ADDR_STATUS:      read_byte = {state_q.rx_en, guard_busy, guard_count};
			default:                        addr_hit  = 1'b0;
		endcase
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		state_d            = state_q;
		state_d.field_prev = rf_field_on;

		// Answer in the first access cycle; read data captured at setup
		state_d.pready  = setup_phase;
		state_d.pslverr = setup_phase && !addr_hit;
		if (setup_phase)
			state_d.prdata = {24'h000000, read_byte};

		if (write_now) begin
			case (paddr)
				rf_route_pkg::ADDR_DRIVE_CTRL:
					state_d.drive_ctrl = pwdata[7:0] & rf_route_pkg::MASK_DRIVE_CTRL;
				rf_route_pkg::ADDR_TX_SOURCE:
					state_d.tx_source = pwdata[7:0] & rf_route_pkg::MASK_TX_SOURCE;
				rf_route_pkg::ADDR_RX_SOURCE:
					state_d.rx_source = pwdata[7:0] & rf_route_pkg::MASK_RX_SOURCE;
				rf_route_pkg::ADDR_THRESHOLD:
					state_d.threshold = pwdata[7:0] & rf_route_pkg::MASK_THRESHOLD;
				rf_route_pkg::ADDR_TEST_SELECT:
					state_d.test_pick = pwdata[2:0];
				default: ;
			endcase
		end

		// Receiver activation sequence
		if (rx_stop)
			state_d.rx_state = rf_route_pkg::RX_IDLE;
		else if (rx_only_start)
			state_d.rx_state = rf_route_pkg::RX_ACTIVE;
		else if (arm_after_tx)
			state_d.rx_state = rf_route_pkg::RX_GUARD;
		else begin
			case (state_q.rx_state)
				rf_route_pkg::RX_GUARD:
					if (!guard_busy)
						state_d.rx_state = rf_route_pkg::RX_ACTIVE;
				rf_route_pkg::RX_IDLE,
				rf_route_pkg::RX_ACTIVE: ;
				default:
					state_d.rx_state = rf_route_pkg::RX_IDLE;
			endcase
		end
		state_d.rx_en = state_d.rx_state == rf_route_pkg::RX_ACTIVE;

		// Decoder feed; anything inside the guard window is ignored
		case (decoder_input_select)
			rf_route_pkg::DEC_LOW:     state_d.dec_in = 1'b0;
			rf_route_pkg::DEC_AUX_MAN: state_d.dec_in = aux_input_pin;
			rf_route_pkg::DEC_ANALOG:  state_d.dec_in = analog_rx_signal;
			rf_route_pkg::DEC_AUX_NRZ: state_d.dec_in = aux_input_pin;
			default:                   state_d.dec_in = 1'b0;
		endcase
		if (guard_busy || !state_q.rx_en)
			state_d.dec_in = 1'b0;

		// Bit decoder qualification
		state_d.accept = rx_strength >= decoder_min_level;
		state_d.coll   = half_bits_valid && state_d.accept
			&& weak_half_level >= collision_threshold;

		// Auxiliary output selection
		state_d.aux_oe  = 1'b1;
		state_d.aux_out = 1'b0;
		case (aux_output_source)
			rf_route_pkg::AUX_TRISTATE: state_d.aux_oe  = 1'b0;
			rf_route_pkg::AUX_LOW:      state_d.aux_out = 1'b0;
			rf_route_pkg::AUX_HIGH:     state_d.aux_out = 1'b1;
			rf_route_pkg::AUX_TEST_BUS: state_d.aux_out = test_bus[state_q.test_pick];
			rf_route_pkg::AUX_MILLER:   state_d.aux_out = miller_envelope;
			rf_route_pkg::AUX_TX_BITS:  state_d.aux_out = tx_serial_bits;
			rf_route_pkg::AUX_RX_BITS:  state_d.aux_out = rx_decoded_bits;
			default:                    state_d.aux_oe  = 1'b0;
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q            <= '0;
			state_q.tx_source  <= rf_route_pkg::RST_TX_SOURCE;
			state_q.rx_source  <= rf_route_pkg::RST_RX_SOURCE;
			state_q.threshold  <= rf_route_pkg::RST_THRESHOLD;
			state_q.drive_ctrl <= rf_route_pkg::RST_DRIVE_CTRL;
			state_q.test_pick  <= rf_route_pkg::RST_TEST_SELECT;
			state_q.rx_state   <= rf_route_pkg::RX_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	assign prdata         = state_q.prdata;
	assign pready         = state_q.pready;
	assign pslverr        = state_q.pslverr;
	assign aux_output_pin    = state_q.aux_out;
	assign aux_output_pin_oe = state_q.aux_oe;
	assign decoder_in     = state_q.dec_in;
	assign rx_enable      = state_q.rx_en;
	assign signal_accept  = state_q.accept;
	assign bit_collision  = state_q.coll;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	aux_tristate_a: assert property (
		aux_output_source == rf_route_pkg::AUX_TRISTATE |=> !aux_output_pin_oe)
		else $error("aux output driven with tristate code");
	aux_reserved_a: assert property (
		aux_output_source >= 4'h8 || aux_output_source == 4'h6 |=> !aux_output_pin_oe)
		else $error("aux output driven for reserved code");
	aux_high_a: assert property (
		aux_output_source == rf_route_pkg::AUX_HIGH |=> aux_output_pin_oe && aux_output_pin)
		else $error("aux output not high for high code");
	aux_testbus_a: assert property (
		aux_output_source == rf_route_pkg::AUX_TEST_BUS
		|=> aux_output_pin == $past(test_bus[state_q.test_pick]))
		else $error("aux output does not follow picked test bus bit");
	guard_hold_a: assert property (
		arm_after_tx && !rx_stop && rx_guard_delay != 6'h0 |=> !rx_enable [*2])
		else $error("receiver enabled inside guard window");
	rx_only_direct_a: assert property (
		rx_only_start && !rx_stop |=> rx_enable)
		else $error("receive-only start waited for guard delay");
	field_start_a: assert property (
		rf_field_on && !state_q.field_prev |=> guard_count == $past(rx_guard_delay))
		else $error("guard counter not started on field switch-on");
	decoder_low_a: assert property (
		decoder_input_select == rf_route_pkg::DEC_LOW |=> !decoder_in)
		else $error("decoder input not low for constant-low code");
	min_level_a: assert property (
		rx_strength < decoder_min_level |=> !signal_accept && !bit_collision)
		else $error("weak signal evaluated by bit decoder");
	collision_level_a: assert property (
		bit_collision |-> $past(weak_half_level) >= $past(collision_threshold))
		else $error("collision flagged below threshold");
	power_down_hold_a: assert property (
		soft_power_down && antenna_driver_source != rf_route_pkg::DRV_TRISTATE
		|=> antenna_drive_pin_a_oe && antenna_drive_pin_b_oe)
		else $error("antenna pin released in power-down");
	aux_miller_a: assert property (
		aux_output_source == rf_route_pkg::AUX_MILLER
		|=> aux_output_pin_oe && aux_output_pin == $past(miller_envelope))
		else $error("aux output not following envelope");
	aux_tx_bits_a: assert property (
		aux_output_source == rf_route_pkg::AUX_TX_BITS
		|=> aux_output_pin_oe && aux_output_pin == $past(tx_serial_bits))
		else $error("aux output not following transmit bits");
	aux_rx_bits_a: assert property (
		aux_output_source == rf_route_pkg::AUX_RX_BITS
		|=> aux_output_pin_oe && aux_output_pin == $past(rx_decoded_bits))
		else $error("aux output not following received bits");
	decoder_manchester_a: assert property (
		decoder_input_select == rf_route_pkg::DEC_AUX_MAN && rx_enable && !guard_busy
		|=> decoder_in == $past(aux_input_pin))
		else $error("decoder not fed from aux input");
	decoder_analog_a: assert property (
		decoder_input_select == rf_route_pkg::DEC_ANALOG && rx_enable && !guard_busy
		|=> decoder_in == $past(analog_rx_signal))
		else $error("decoder not fed from analog receiver");
	decoder_nrz_a: assert property (
		decoder_input_select == rf_route_pkg::DEC_AUX_NRZ && rx_enable && !guard_busy
		|=> decoder_in == $past(aux_input_pin))
		else $error("decoder not fed from aux input for NRZ");
	guard_quiet_a: assert property (
		guard_busy |=> !decoder_in)
		else $error("decoder input passed during guard window");
endmodule
